// [fcf_pkg.sv]
// fcf_pkg: offsets, field positions and reset values of the flash
// command-index and fault-inject configuration bank.
// assumes an APB slave with 32-bit data and an 8-bit byte address.
package fcf_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned FCF_IDX_CMD_INDEX = 'h2;
  localparam int unsigned FCF_IDX_CONFIG    = 'h4;
  localparam int unsigned FCF_IDX_ERR_CFG   = 'h5;
  localparam int unsigned FCF_IDX_STATUS    = 'h6;
  localparam int unsigned FCF_IDX_ERR_STAT  = 'h7;
  localparam int unsigned FCF_IDX_CMD_WORD  = 'ha;
  localparam int unsigned FCF_IDX_FACTORY   = 'hc;
  localparam int unsigned FCF_IDX_ECC_CAP   = 'he;
  localparam int unsigned FCF_ADDR_W        = 8;
  localparam logic [7:0] FCF_ADDR_CMD_INDEX = 8'(4 * FCF_IDX_CMD_INDEX);
  localparam logic [7:0] FCF_ADDR_CONFIG    = 8'(4 * FCF_IDX_CONFIG);
  localparam logic [7:0] FCF_ADDR_ERR_CFG   = 8'(4 * FCF_IDX_ERR_CFG);
  localparam logic [7:0] FCF_ADDR_STATUS    = 8'(4 * FCF_IDX_STATUS);
  localparam logic [7:0] FCF_ADDR_ERR_STAT  = 8'(4 * FCF_IDX_ERR_STAT);
  localparam logic [7:0] FCF_ADDR_CMD_WORD  = 8'(4 * FCF_IDX_CMD_WORD);
  localparam logic [7:0] FCF_ADDR_FACTORY   = 8'(4 * FCF_IDX_FACTORY);
  localparam logic [7:0] FCF_ADDR_ECC_CAP   = 8'(4 * FCF_IDX_ECC_CAP);
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned FCF_SEL_W        = 3;
  localparam int unsigned FCF_CFG_DONE_IE  = 7;
  localparam int unsigned FCF_CFG_IGN_SF   = 4;
  localparam int unsigned FCF_CFG_FORCE_DF = 1;
  localparam int unsigned FCF_CFG_FORCE_SF = 0;
  localparam int unsigned FCF_ECFG_DF_IE   = 1;
  localparam int unsigned FCF_ECFG_SF_IE   = 0;
  localparam int unsigned FCF_STAT_DONE    = 7;
  localparam int unsigned FCF_ESTAT_DF     = 1;
  localparam int unsigned FCF_ESTAT_SF     = 0;
  localparam logic [7:0]  FCF_CFG_MASK     = 8'h93;
  localparam logic [7:0]  FCF_ECFG_MASK    = 8'h03;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] FCF_CFG_RST   = 8'h00;
  localparam logic [7:0] FCF_ECFG_RST  = 8'h00;
  localparam logic [2:0] FCF_SEL_RST   = 3'h0;
  localparam logic       FCF_DONE_RST  = 1'b1;
endpackage : fcf_pkg

// [fcf_regs.sv]
// fcf_regs: command-object index, factory-test reserved register and
// flash configuration with ecc fault injection, behind an apb slave.
// assumes the command engine and ecc checker run on ref_clk_in and
// give one-cycle pulses; apb answers with no wait state while ce_in high.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// Contract
// - index field picks the command-object word that array accesses reach
// - index register keeps only its index bits, others read zero
// - factory-test register reads zero and ignores writes
// - configuration keeps four bits writable, the rest read zero
// - done interrupt requested while done flag and its enable are set
// - ignore bit hides real single faults from flag and interrupt
// - force-double bit makes every array read set double flag
// - forced double fault interrupts only with double enable set
// - forced double keeps ecc capture unless a real double or unignored single fault
// - without forcing, double flag sets only on a real double fault
// - force-single bit makes every array read set single flag
// - forced single fault interrupts only with single enable set
// - forced single keeps ecc capture unless a real unignored single or double fault
// - without forcing, single flag sets only on a real single fault
// - writing one to a set done flag clears it and launches a command
// - double interrupt requested while double flag and enable set
module fcf_regs
  import fcf_pkg::*;
#(
  parameter int unsigned WORD_W = 16,
  parameter int unsigned DEPTH  = 8
) (
  // clock, reset, enable
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [FCF_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // command engine
  input  wire logic                  cmd_done_in,
  input  wire logic                  cmd_violation_in,
  output logic                       cmd_launch_out,
  output logic      [FCF_SEL_W-1:0]  cmd_word_select_out,
  output logic      [WORD_W-1:0]     cmd_word_out,
  // array read path
  input  wire logic                  array_read_in,
  input  wire logic                  ecc_single_in,
  input  wire logic                  ecc_double_in,
  input  wire logic [WORD_W-1:0]     ecc_info_in,
  // interrupt requests
  output logic                       cmd_done_irq_out,
  output logic                       double_fault_irq_out,
  output logic                       single_fault_irq_out
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH != (1 << FCF_SEL_W)) begin : g_bad_depth
    $error("DEPTH must equal the index range");
  end
  if (WORD_W < 1 || WORD_W > 32) begin : g_bad_width
    $error("WORD_W must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [FCF_SEL_W-1:0] cmd_word_select;
  logic [7:0]           flash_configuration;
  logic [7:0]           error_config_reg;
  logic                 cmd_done_flag;
  logic                 double_fault_flag;
  logic                 single_fault_flag;
  logic [WORD_W-1:0]    ecc_error_capture;
  logic [WORD_W-1:0]    command_object_array [DEPTH];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic       setup;
  logic       wr;
  logic       hit;
  logic [7:0] wbyte;
  logic [31:0] next_rdata;

  assign setup = ce_in & psel_in & ~penable_in;
  assign wr    = ce_in & psel_in & penable_in & pwrite_in;
  assign wbyte = pwdata_in[7:0];
  assign pready_out = ce_in;

  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr_in)
      FCF_ADDR_CMD_INDEX: next_rdata = 32'(cmd_word_select);
      FCF_ADDR_CONFIG:    next_rdata = 32'(flash_configuration);
      FCF_ADDR_ERR_CFG:   next_rdata = 32'(error_config_reg);
      FCF_ADDR_STATUS:    next_rdata = 32'(cmd_done_flag) << FCF_STAT_DONE;
      FCF_ADDR_ERR_STAT: begin
        next_rdata[FCF_ESTAT_DF] = double_fault_flag;
        next_rdata[FCF_ESTAT_SF] = single_fault_flag;
      end
      FCF_ADDR_CMD_WORD:  next_rdata = 32'(command_object_array[cmd_word_select]);
      FCF_ADDR_FACTORY:   next_rdata = 32'h0000_0000;
      FCF_ADDR_ECC_CAP:   next_rdata = 32'(ecc_error_capture);
      default:            hit = 1'b0;
    endcase
  end

  // read data and error are taken in the setup cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
      pslverr_out <= ~hit;
    end
  end

  // ----------------------------------------------------------------
  // index and command-object array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_word_select <= FCF_SEL_RST;
    end else if (wr && paddr_in == FCF_ADDR_CMD_INDEX) begin
      cmd_word_select <= wbyte[FCF_SEL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        command_object_array[i] <= '0;
      end
    end else if (wr && paddr_in == FCF_ADDR_CMD_WORD) begin
      command_object_array[cmd_word_select] <= pwdata_in[WORD_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_word_select_out <= FCF_SEL_RST;
      cmd_word_out        <= '0;
    end else if (ce_in) begin
      cmd_word_select_out <= cmd_word_select;
      cmd_word_out        <= command_object_array[cmd_word_select];
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flash_configuration <= FCF_CFG_RST;
    end else if (wr && paddr_in == FCF_ADDR_CONFIG) begin
      flash_configuration <= wbyte & FCF_CFG_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      error_config_reg <= FCF_ECFG_RST;
    end else if (wr && paddr_in == FCF_ADDR_ERR_CFG) begin
      error_config_reg <= wbyte & FCF_ECFG_MASK;
    end
  end

  logic force_df;
  logic force_sf;
  logic ign_sf;
  assign force_df = flash_configuration[FCF_CFG_FORCE_DF];
  assign force_sf = flash_configuration[FCF_CFG_FORCE_SF];
  assign ign_sf   = flash_configuration[FCF_CFG_IGN_SF];

  // ----------------------------------------------------------------
  // command done flag and launch
  // ----------------------------------------------------------------
  logic launch;
  logic done_set;
  assign launch   = wr && paddr_in == FCF_ADDR_STATUS && wbyte[FCF_STAT_DONE] && cmd_done_flag;
  assign done_set = ce_in & (cmd_done_in | cmd_violation_in);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_done_flag  <= FCF_DONE_RST;
      cmd_launch_out <= 1'b0;
    end else if (ce_in) begin
      cmd_launch_out <= launch;
      if (done_set) begin
        cmd_done_flag <= 1'b1;
      end else if (launch) begin
        cmd_done_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault flags and ecc capture
  // ----------------------------------------------------------------
  logic rd;
  logic real_sf;
  logic real_df;
  logic clr_df;
  logic clr_sf;
  assign rd      = ce_in & array_read_in;
  assign real_df = rd & ecc_double_in;
  assign real_sf = rd & ecc_single_in & ~ign_sf;
  assign clr_df  = wr && paddr_in == FCF_ADDR_ERR_STAT && wbyte[FCF_ESTAT_DF];
  assign clr_sf  = wr && paddr_in == FCF_ADDR_ERR_STAT && wbyte[FCF_ESTAT_SF];

  // a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      double_fault_flag <= 1'b0;
    end else if (real_df || (rd && force_df)) begin
      double_fault_flag <= 1'b1;
    end else if (clr_df) begin
      double_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      single_fault_flag <= 1'b0;
    end else if (real_sf || (rd && force_sf)) begin
      single_fault_flag <= 1'b1;
    end else if (clr_sf) begin
      single_fault_flag <= 1'b0;
    end
  end

  // only genuine faults load the capture, forced ones never
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ecc_error_capture <= '0;
    end else if (real_df || real_sf) begin
      ecc_error_capture <= ecc_info_in;
    end
  end

  // ----------------------------------------------------------------
  // interrupt levels
  // ----------------------------------------------------------------
  assign cmd_done_irq_out     = cmd_done_flag & flash_configuration[FCF_CFG_DONE_IE];
  assign double_fault_irq_out = double_fault_flag & error_config_reg[FCF_ECFG_DF_IE];
  assign single_fault_irq_out = single_fault_flag & error_config_reg[FCF_ECFG_SF_IE];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_reg_write(logic [7:0] a);
    ce_in && psel_in && !penable_in && pwrite_in && paddr_in == a
      ##1 ce_in && psel_in && penable_in && $stable(paddr_in) && $stable(pwdata_in);
  endsequence

  sequence s_reg_read(logic [7:0] a);
    ce_in && psel_in && !penable_in && !pwrite_in && paddr_in == a;
  endsequence

  property p_index_write;
    logic [2:0] v;
    (s_reg_write(FCF_ADDR_CMD_INDEX), v = pwdata_in[2:0]) |=> cmd_word_select == v && cmd_word_select_out == $past(cmd_word_select_out);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index write not stored");

  property p_word_select;
    ce_in ##1 ce_in |-> cmd_word_select_out == $past(cmd_word_select) && cmd_word_out == $past(command_object_array[cmd_word_select]);
  endproperty
  a_word_select: assert property (p_word_select) else $error("selected word mismatch");

  property p_factory_zero;
    s_reg_read(FCF_ADDR_FACTORY) |=> prdata_out == 32'h0000_0000 && !pslverr_out;
  endproperty
  a_factory_zero: assert property (p_factory_zero) else $error("factory register not zero");

  property p_config_mask;
    s_reg_write(FCF_ADDR_CONFIG) |=> flash_configuration == ($past(pwdata_in[7:0]) & FCF_CFG_MASK) ##1 !(|(flash_configuration & ~FCF_CFG_MASK));
  endproperty
  a_config_mask: assert property (p_config_mask) else $error("config write wrong");

  property p_done_irq;
    cmd_done_irq_out == (cmd_done_flag && flash_configuration[FCF_CFG_DONE_IE]);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done irq wrong");

  property p_ignore_single;
    rd && ecc_single_in && ign_sf && !force_sf && !single_fault_flag |=> !single_fault_flag && !single_fault_irq_out;
  endproperty
  a_ignore_single: assert property (p_ignore_single) else $error("ignored fault reported");

  property p_force_double;
    rd && force_df |=> double_fault_flag ##0 (error_config_reg[FCF_ECFG_DF_IE] == double_fault_irq_out);
  endproperty
  a_force_double: assert property (p_force_double) else $error("forced double lost");

  property p_capture_hold;
    rd && !ecc_double_in && !ecc_single_in && (force_df || force_sf) |=> $stable(ecc_error_capture);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture moved on forced fault");

  property p_double_only_real;
    rd && !force_df && !ecc_double_in && !double_fault_flag |=> !double_fault_flag;
  endproperty
  a_double_only_real: assert property (p_double_only_real) else $error("spurious double flag");

  property p_force_single;
    rd && force_sf |=> single_fault_flag ##0 (error_config_reg[FCF_ECFG_SF_IE] == single_fault_irq_out);
  endproperty
  a_force_single: assert property (p_force_single) else $error("forced single lost");

  property p_single_only_real;
    rd && !force_sf && !ecc_single_in && !single_fault_flag |=> !single_fault_flag;
  endproperty
  a_single_only_real: assert property (p_single_only_real) else $error("spurious single flag");

  property p_launch;
    launch && !done_set |=> cmd_launch_out && !cmd_done_flag ##1 (!$past(ce_in) || !cmd_launch_out);
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not clear done");

  property p_irq_level;
    single_fault_irq_out && !clr_sf && !(wr && paddr_in == FCF_ADDR_ERR_CFG) |=> single_fault_irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level dropped");

endmodule : fcf_regs

// [fcf_regs_test.sv]
// fcf_regs_test: self-checking bench for the command index and fault-inject
// configuration bank, driven as an apb master with no wait-state assumption.
// assumes fcf_pkg and fcf_regs are compiled first; ce_in is held high except in t_freeze.
`timescale 1ns/1ps
module fcf_regs_test;
  import fcf_pkg::*;
  localparam int unsigned WW = 16;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic          ref_clk_in = 1'b0;
  logic          rstn_in    = 1'b0;
  logic          ce_in      = 1'b1;
  logic          psel       = 1'b0;
  logic          penable    = 1'b0;
  logic          pwrite     = 1'b0;
  logic [7:0]    paddr      = 8'h00;
  logic [31:0]   pwdata     = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          cmd_done   = 1'b0;
  logic          cmd_viol   = 1'b0;
  logic          launch;
  logic [2:0]    wsel;
  logic [WW-1:0] word;
  logic          arr_rd     = 1'b0;
  logic          ecc_s      = 1'b0;
  logic          ecc_d      = 1'b0;
  logic [WW-1:0] ecc_info   = '0;
  logic          done_irq;
  logic          df_irq;
  logic          sf_irq;
  int            bad_count  = 0;
  int            checked    = 0;

  fcf_regs #(.WORD_W(WW), .DEPTH(8)) uut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmd_done_in(cmd_done), .cmd_violation_in(cmd_viol), .cmd_launch_out(launch),
    .cmd_word_select_out(wsel), .cmd_word_out(word), .array_read_in(arr_rd),
    .ecc_single_in(ecc_s), .ecc_double_in(ecc_d), .ecc_info_in(ecc_info),
    .cmd_done_irq_out(done_irq), .double_fault_irq_out(df_irq), .single_fault_irq_out(sf_irq)
  );

  always #12.5 ref_clk_in = ~ref_clk_in;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, exp, rd);
  endtask : rdchk

  // one array read, irq sampled a cycle after the flags land
  task automatic arr(input logic s, input logic d, input logic [WW-1:0] info);
    @(posedge ref_clk_in);
    arr_rd <= 1'b1; ecc_s <= s; ecc_d <= d; ecc_info <= info;
    @(posedge ref_clk_in);
    arr_rd <= 1'b0; ecc_s <= 1'b0; ecc_d <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask : arr

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_and_masks();
    logic [31:0] rd;
    logic        err;
    rdchk("cfg reset", FCF_ADDR_CONFIG, 32'h0);
    rdchk("index reset", FCF_ADDR_CMD_INDEX, 32'h0);
    rdchk("status reset", FCF_ADDR_STATUS, 32'h80);
    chk("done irq off", 32'h0, {31'h0, done_irq});
    wr(FCF_ADDR_CMD_INDEX, 32'hffff_ffff);
    rdchk("index mask", FCF_ADDR_CMD_INDEX, 32'h7);
    wr(FCF_ADDR_CONFIG, 32'hffff_ffff);
    rdchk("cfg mask", FCF_ADDR_CONFIG, 32'h93);
    wr(FCF_ADDR_CONFIG, 32'h6c);
    rdchk("cfg clear", FCF_ADDR_CONFIG, 32'h0);
    wr(FCF_ADDR_FACTORY, 32'hffff_ffff);
    rdchk("factory", FCF_ADDR_FACTORY, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, rd, err);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : t_reset_and_masks

  task automatic t_index();
    for (int i = 0; i < 8; i++) begin
      wr(FCF_ADDR_CMD_INDEX, 32'(i));
      wr(FCF_ADDR_CMD_WORD, 32'h1000 + 32'(i) * 32'h111);
    end
    for (int i = 7; i >= 0; i--) begin
      wr(FCF_ADDR_CMD_INDEX, 32'(i));
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("select out", 32'(i), {29'h0, wsel});
      chk("word out", 32'h1000 + 32'(i) * 32'h111, {16'h0, word});
      rdchk("word read", FCF_ADDR_CMD_WORD, 32'h1000 + 32'(i) * 32'h111);
    end
  endtask : t_index

  task automatic t_done(input logic viol);
    int pulses;
    pulses = 0;
    wr(FCF_ADDR_CONFIG, 32'h80);
    #1;
    chk("done irq on", 32'h1, {31'h0, done_irq});
    wr(FCF_ADDR_STATUS, 32'h80);
    #1;
    for (int k = 0; k < 4; k++) begin
      if (launch === 1'b1) pulses++;
      @(posedge ref_clk_in);
      #1;
    end
    chk("launch pulses", 32'h1, 32'(pulses));
    chk("done irq busy", 32'h0, {31'h0, done_irq});
    rdchk("status busy", FCF_ADDR_STATUS, 32'h0);
    @(posedge ref_clk_in);
    cmd_done <= ~viol; cmd_viol <= viol;
    @(posedge ref_clk_in);
    cmd_done <= 1'b0; cmd_viol <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("done irq again", 32'h1, {31'h0, done_irq});
    wr(FCF_ADDR_CONFIG, 32'h0);
    #1;
    chk("done irq masked", 32'h0, {31'h0, done_irq});
  endtask : t_done

  // b selects the double (1) or the single (0) fault path
  task automatic t_fault(input int b);
    logic [31:0] m;
    m = 32'h1 << b;
    wr(FCF_ADDR_ERR_CFG, 32'h0);
    wr(FCF_ADDR_ERR_STAT, 32'h3);
    arr(1'b0, 1'b0, 16'h1111);
    rdchk("no fault", FCF_ADDR_ERR_STAT, 32'h0);
    arr(b == 0, b == 1, 16'h1234 + 16'(b));
    rdchk("real fault", FCF_ADDR_ERR_STAT, m);
    rdchk("capture real", FCF_ADDR_ECC_CAP, 32'h1234 + 32'(b));
    chk("irq disabled", 32'h0, {31'h0, b ? df_irq : sf_irq});
    wr(FCF_ADDR_ERR_CFG, m);
    #1;
    chk("irq enabled", 32'h1, {31'h0, b ? df_irq : sf_irq});
    wr(FCF_ADDR_ERR_STAT, 32'h3);
    #1;
    chk("irq cleared", 32'h0, {31'h0, b ? df_irq : sf_irq});
    wr(FCF_ADDR_CONFIG, m);
    arr(1'b0, 1'b0, 16'hbeef);
    chk("forced irq", 32'h1, {31'h0, b ? df_irq : sf_irq});
    rdchk("forced flag", FCF_ADDR_ERR_STAT, m);
    rdchk("capture kept", FCF_ADDR_ECC_CAP, 32'h1234 + 32'(b));
    rdchk("force sticks", FCF_ADDR_CONFIG, m);
    wr(FCF_ADDR_ERR_STAT, 32'h3);
    wr(FCF_ADDR_ERR_CFG, 32'h0);
    arr(1'b0, 1'b0, 16'h0);
    chk("forced no irq", 32'h0, {31'h0, b ? df_irq : sf_irq});
    wr(FCF_ADDR_CONFIG, 32'h0);
    wr(FCF_ADDR_ERR_STAT, 32'h3);
  endtask : t_fault

  task automatic t_ignore();
    wr(FCF_ADDR_ERR_CFG, 32'h1);
    wr(FCF_ADDR_CONFIG, 32'h10);
    arr(1'b1, 1'b0, 16'h5a5a);
    rdchk("ignored flag", FCF_ADDR_ERR_STAT, 32'h0);
    chk("ignored irq", 32'h0, {31'h0, sf_irq});
    wr(FCF_ADDR_CONFIG, 32'h0);
    arr(1'b1, 1'b0, 16'h5a5a);
    rdchk("reported flag", FCF_ADDR_ERR_STAT, 32'h1);
    chk("reported irq", 32'h1, {31'h0, sf_irq});
  endtask : t_ignore

  // clock enable low: a real double fault must leave flags and capture alone
  task automatic t_freeze();
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    arr(1'b0, 1'b1, 16'h7777);
    chk("pready frozen", 32'h0, {31'h0, pready});
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    rdchk("frozen flags", FCF_ADDR_ERR_STAT, 32'h1);
    rdchk("frozen capture", FCF_ADDR_ECC_CAP, 32'h5a5a);
  endtask : t_freeze

  // ------------------------------------------------------------------
  // sequencing and verdict
  // ------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_reset_and_masks();
    t_index();
    t_done(1'b0);
    t_done(1'b1);
    t_fault(1);
    t_fault(0);
    t_ignore();
    t_freeze();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    final_report();
  end
endmodule : fcf_regs_test
